// ===== common/serr_mask_pkg.sv
// Package with offsets, field positions and reset values for the system error event gating block
package serr_mask_pkg;
  localparam logic [7:0] disable_offset = 8'h64;
  localparam logic [7:0] status_offset = 8'h68;
  localparam int disable_lane = 0;
  localparam int status_lane = 2;
  localparam int reason_count = 8;
  localparam logic [7:0] disable_reset = 8'h00;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] disable_writable = 8'h7E;
  // Event positions, shared by the disable byte and the status byte
  localparam int pos_addr_parity = 0;
  localparam int pos_posted_parity = 1;
  localparam int pos_posted_fail = 2;
  localparam int pos_posted_target_abort = 3;
  localparam int pos_posted_master_abort = 4;
  localparam int pos_delayed_write_fail = 5;
  localparam int pos_delayed_read_fail = 6;
  localparam int pos_master_timeout = 7;
endpackage : serr_mask_pkg

// ===== rtl/serr_reason_bit.sv
// One sticky reason bit with write-one-to-clear where the set wins
`timescale 1ns/10ps
module serr_reason_bit
  import serr_mask_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  output logic flag
);
  typedef struct packed {
    logic flag;
  } bit_state_type;

  bit_state_type state_ff;
  bit_state_type nxt_state;

  // A set in the same cycle as the clear keeps the flag, so no event is lost
  always_comb begin
    nxt_state = state_ff;
    if (clear_pulse) begin
      nxt_state.flag = 1'b0;
    end
    if (set_pulse) begin
      nxt_state.flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign flag = state_ff.flag;

  property p_set_wins;
    @(posedge clk) disable iff (srst) set_pulse |=> flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("reason bit lost a set");

  property p_clear_only;
    @(posedge clk) disable iff (srst) (clear_pulse && !set_pulse) |=> !flag;
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("reason bit not cleared");
endmodule : serr_reason_bit

// ===== rtl/bridge_serr_event_mask.sv
// System error event gating with disable byte, reason status byte and active-low error output
//
// Functional notes
// - Disable byte at 0x64, lane 0 only.
// - Bits 7 and 0 read zero, ignore writes.
// - Bit 6 masks delayed read failure.
// - Bit 5 masks delayed write failure.
// - Bit 4 masks posted write master abort.
// - Bit 3 masks posted write target abort.
// - Bit 2 masks posted write non-delivery.
// - Bit 1 masks posted write parity error.
// - Mask set never asserts the error output.
// - Mask clear asserts only with reporting enabled.
// - Record reasons at 0x68, write one clears.
`timescale 1ns/10ps
module bridge_serr_event_mask
  import serr_mask_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [7:0] cfg_offset,
  input wire logic [3:0] primary_byte_enables_n,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic error_report_enable,
  input wire logic addr_parity_event,
  input wire logic posted_parity_event,
  input wire logic posted_fail_event,
  input wire logic posted_target_abort_event,
  input wire logic posted_master_abort_event,
  input wire logic delayed_write_fail_event,
  input wire logic delayed_read_fail_event,
  input wire logic master_timeout_event,
  output logic system_error_out_n
);
  // Disable byte, registered read data and the output live in one state record
  typedef struct packed {
    logic [7:0] event_disable;
    logic [31:0] rdata;
    logic serr_n;
  } top_state_type;

  top_state_type state_ff;
  top_state_type nxt_state;
  // Event vector and its gated forms, indexed by reason position
  logic [7:0] events;
  logic [7:0] maskable;
  logic [7:0] reported;
  logic [7:0] reason_flags;
  logic [7:0] status_clear;
  logic disable_wr;
  logic status_wr;

  // Gather the event pulses by their reason position
  always_comb begin
    events = '0;
    events[pos_addr_parity] = addr_parity_event;
    events[pos_posted_parity] = posted_parity_event;
    events[pos_posted_fail] = posted_fail_event;
    events[pos_posted_target_abort] = posted_target_abort_event;
    events[pos_posted_master_abort] = posted_master_abort_event;
    events[pos_delayed_write_fail] = delayed_write_fail_event;
    events[pos_delayed_read_fail] = delayed_read_fail_event;
    events[pos_master_timeout] = master_timeout_event;
  end

  // Only the six bridge events have a disable bit; the rest are gated by the reporting enable alone
  assign maskable = disable_writable;
  assign reported = events & ~(state_ff.event_disable & maskable) & {8{error_report_enable}};

  // Byte enables are active low; a write touches only its own lane
  assign disable_wr = cfg_write && (cfg_offset == disable_offset)
                      && !primary_byte_enables_n[disable_lane];
  assign status_wr = cfg_write && (cfg_offset == status_offset) && !primary_byte_enables_n[status_lane];
  // Only the status lane carries clear bits; other lanes of the dword are ignored
  assign status_clear = status_wr ? cfg_wdata[status_lane*8 +: 8] : 8'h00;

  // One sticky reason bit per event
  genvar gi;
  generate
    for (gi = 0; gi < reason_count; gi++) begin : g_reason
      serr_reason_bit u_bit (
        .clk(clk),
        .srst(srst),
        .set_pulse(reported[gi]),
        .clear_pulse(status_clear[gi]),
        .flag(reason_flags[gi])
      );
    end
  endgenerate

  // Register update, read data and error output
  always_comb begin
    nxt_state = state_ff;
    // Reserved bits are dropped at the write so they can never read back set
    if (disable_wr) begin
      nxt_state.event_disable = cfg_wdata[7:0] & disable_writable;
    end
    nxt_state.rdata = 32'h0000_0000;
    // Reads have no side effects; status bits clear only by writes
    if (cfg_read) begin
      case (cfg_offset)
        disable_offset: nxt_state.rdata = {24'h00_0000, state_ff.event_disable};
        status_offset: nxt_state.rdata = {8'h00, reason_flags, 16'h0000};
        default: nxt_state.rdata = 32'h0000_0000;
      endcase
    end
    nxt_state.serr_n = ~(|reported);
  end

  // Synchronous reset; the output idles high so a reset never looks like an error
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff.event_disable <= disable_reset;
      state_ff.rdata <= 32'h0000_0000;
      state_ff.serr_n <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Data outputs come straight from flip-flops
  assign cfg_rdata = state_ff.rdata;
  assign system_error_out_n = state_ff.serr_n;

  // Checks
  property p_lane_gate;
    @(posedge clk) disable iff (srst)
      (cfg_write && cfg_offset == disable_offset && primary_byte_enables_n[disable_lane])
      |=> $stable(state_ff.event_disable);
  endproperty
  a_lane_gate: assert property (p_lane_gate) else $error("disable byte changed without lane");

  property p_lane_write;
    @(posedge clk) disable iff (srst)
      disable_wr |=> state_ff.event_disable == ($past(cfg_wdata[7:0]) & 8'h7E);
  endproperty
  a_lane_write: assert property (p_lane_write) else $error("disable byte not written");

  property p_reserved_zero;
    @(posedge clk) disable iff (srst) state_ff.event_disable[7] == 1'b0 && state_ff.event_disable[0] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved disable bit set");

  property p_read_fail_mask;
    @(posedge clk) disable iff (srst)
      (delayed_read_fail_event && state_ff.event_disable[6] && !(|(events & 8'hBF))) |=> system_error_out_n;
  endproperty
  a_read_fail_mask: assert property (p_read_fail_mask) else $error("masked read failure asserted");

  property p_write_fail_mask;
    @(posedge clk) disable iff (srst)
      (delayed_write_fail_event && state_ff.event_disable[5] && !(|(events & 8'hDF))) |=> system_error_out_n;
  endproperty
  a_write_fail_mask: assert property (p_write_fail_mask) else $error("masked write failure asserted");

  property p_master_abort_mask;
    @(posedge clk) disable iff (srst)
      (posted_master_abort_event && state_ff.event_disable[4] && !(|(events & 8'hEF))) |=> system_error_out_n;
  endproperty
  a_master_abort_mask: assert property (p_master_abort_mask) else $error("masked master abort asserted");

  property p_target_abort_mask;
    @(posedge clk) disable iff (srst)
      (posted_target_abort_event && state_ff.event_disable[3] && !(|(events & 8'hF7))) |=> system_error_out_n;
  endproperty
  a_target_abort_mask: assert property (p_target_abort_mask) else $error("masked target abort asserted");

  property p_posted_fail_mask;
    @(posedge clk) disable iff (srst)
      (posted_fail_event && state_ff.event_disable[2] && !(|(events & 8'hFB))) |=> system_error_out_n;
  endproperty
  a_posted_fail_mask: assert property (p_posted_fail_mask) else $error("masked posted failure asserted");

  property p_parity_mask;
    @(posedge clk) disable iff (srst)
      (posted_parity_event && state_ff.event_disable[1] && !(|(events & 8'hFD))) |=> system_error_out_n;
  endproperty
  a_parity_mask: assert property (p_parity_mask) else $error("masked parity error asserted");

  property p_masked_silent;
    @(posedge clk) disable iff (srst)
      !(|(events & ~(state_ff.event_disable & 8'h7E))) |=> system_error_out_n;
  endproperty
  a_masked_silent: assert property (p_masked_silent) else $error("error asserted with no open event");

  property p_enable_needed;
    @(posedge clk) disable iff (srst) !error_report_enable |=> system_error_out_n;
  endproperty
  a_enable_needed: assert property (p_enable_needed) else $error("error asserted while reporting off");

  property p_open_asserts;
    @(posedge clk) disable iff (srst)
      (error_report_enable && |(events & ~(state_ff.event_disable & 8'h7E))) |=> !system_error_out_n;
  endproperty
  a_open_asserts: assert property (p_open_asserts) else $error("open event did not assert error");

  property p_reason_recorded;
    @(posedge clk) disable iff (srst) !system_error_out_n |-> (reason_flags != 8'h00) || $past(status_wr);
  endproperty
  a_reason_recorded: assert property (p_reason_recorded) else $error("error without reason recorded");

  // The disable byte moves only on a lane-0 write at its own offset
  property p_disable_hold;
    @(posedge clk) disable iff (srst) !disable_wr |=> $stable(state_ff.event_disable);
  endproperty
  a_disable_hold: assert property (p_disable_hold) else $error("disable byte changed without a write");

  // A status write without its lane must not clear anything
  property p_clear_lane;
    @(posedge clk) disable iff (srst)
      (cfg_write && cfg_offset == status_offset && primary_byte_enables_n[status_lane] && !(|reported))
      |=> reason_flags == $past(reason_flags);
  endproperty
  a_clear_lane: assert property (p_clear_lane) else $error("status cleared without lane");

  // A status write with its lane clears every bit written as one
  property p_status_write;
    @(posedge clk) disable iff (srst)
      (status_wr && !(|reported)) |=> (reason_flags & $past(status_clear)) == 8'h00;
  endproperty
  a_status_write: assert property (p_status_write) else $error("status bit not cleared by write");

  // Read data answers one cycle after the strobe and is zero otherwise
  property p_read_disable;
    @(posedge clk) disable iff (srst)
      (cfg_read && cfg_offset == disable_offset)
      |=> cfg_rdata == {24'h00_0000, $past(state_ff.event_disable)};
  endproperty
  a_read_disable: assert property (p_read_disable) else $error("disable byte read back wrong");

  property p_read_status;
    @(posedge clk) disable iff (srst)
      (cfg_read && cfg_offset == status_offset)
      |=> cfg_rdata == {8'h00, $past(reason_flags), 16'h0000};
  endproperty
  a_read_status: assert property (p_read_status) else $error("status byte read back wrong");

  property p_read_quiet;
    @(posedge clk) disable iff (srst)
      !(cfg_read && (cfg_offset == disable_offset || cfg_offset == status_offset))
      |=> cfg_rdata == 32'h0000_0000;
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read data not zero");

  // Error output stands low one cycle per reported cycle, never longer
  property p_one_cycle;
    @(posedge clk) disable iff (srst) (!system_error_out_n && !(|reported)) |=> system_error_out_n;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("error output held too long");

  // Events without a disable bit are gated by the reporting enable alone
  property p_unmaskable;
    @(posedge clk) disable iff (srst)
      (error_report_enable && (addr_parity_event || master_timeout_event)) |=> !system_error_out_n;
  endproperty
  a_unmaskable: assert property (p_unmaskable) else $error("ungated event not reported");

  // Reset is checked outside the disable so that its own effect is seen
  property p_reset_idle;
    @(posedge clk) srst
      |=> system_error_out_n && cfg_rdata == 32'h0000_0000
      && state_ff.event_disable == disable_reset && reason_flags == status_reset;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("state not idle after reset");

  // Per reason: a reported event sets its bit, and nothing else does
  generate
    for (gi = 0; gi < reason_count; gi++) begin : g_reason_chk
      property p_reason_set;
        @(posedge clk) disable iff (srst) reported[gi] |=> reason_flags[gi];
      endproperty
      a_reason_set: assert property (p_reason_set) else $error("reported event left no reason");

      // Masked or unreported events must never leave a trace
      property p_reason_only;
        @(posedge clk) disable iff (srst) (!reason_flags[gi] && !reported[gi]) |=> !reason_flags[gi];
      endproperty
      a_reason_only: assert property (p_reason_only) else $error("reason set without report");

      // Reporting off means no reason is recorded either
      property p_quiet_enable;
        @(posedge clk) disable iff (srst) (!error_report_enable && !reason_flags[gi]) |=> !reason_flags[gi];
      endproperty
      a_quiet_enable: assert property (p_quiet_enable) else $error("reason set while reporting off");

      // Unmasked with reporting on, each bit alone pulls the output low
      property p_open_bit;
        @(posedge clk) disable iff (srst)
          (events[gi] && error_report_enable && !(state_ff.event_disable[gi] && maskable[gi]))
          |=> !system_error_out_n;
      endproperty
      a_open_bit: assert property (p_open_bit) else $error("open event bit not reported");
    end
  endgenerate

  c_masked_event: cover property (@(posedge clk) disable iff (srst) posted_parity_event && state_ff.event_disable[1]);
  c_error_out: cover property (@(posedge clk) disable iff (srst) !system_error_out_n);
  c_status_clear: cover property (@(posedge clk) disable iff (srst) status_wr && |reason_flags);
  c_set_and_clear: cover property (@(posedge clk) disable iff (srst) |(reported & status_clear));
  c_all_masked: cover property (@(posedge clk) disable iff (srst)
    |(events & disable_writable) && state_ff.event_disable == disable_writable);
endmodule : bridge_serr_event_mask

// ===== verif/cfg_host.sv
// Primary bus host model issuing single configuration reads and writes
`timescale 1ns/10ps
module cfg_host (
  input wire logic clk,
  output logic cfg_write,
  output logic cfg_read,
  output logic [7:0] cfg_offset,
  output logic [3:0] primary_byte_enables_n,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata
);
  // Released lines show inverted leftovers, so stale values never pass as live ones
  task automatic idle_bus();
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    cfg_offset = ~cfg_offset;
    primary_byte_enables_n = ~primary_byte_enables_n;
    cfg_wdata = ~cfg_wdata;
  endtask : idle_bus

  // Request held across the taking edge, released at the following falling edge
  task automatic wr(input logic [7:0] off, input logic [3:0] be_n, input logic [31:0] data);
    @(negedge clk);
    cfg_write = 1'b1;
    cfg_offset = off;
    primary_byte_enables_n = be_n;
    cfg_wdata = data;
    @(negedge clk);
    idle_bus();
  endtask : wr

  // Read data is registered at the taking edge and stands for one cycle only
  task automatic rd(input logic [7:0] off, output logic [31:0] data);
    @(negedge clk);
    cfg_read = 1'b1;
    cfg_offset = off;
    primary_byte_enables_n = 4'b0000;
    @(negedge clk);
    idle_bus();
    data = cfg_rdata;
  endtask : rd

  initial begin
    cfg_offset = 8'h00;
    primary_byte_enables_n = 4'b1111;
    cfg_wdata = 32'h0000_0000;
    idle_bus();
  end
endmodule : cfg_host

// ===== verif/tb.sv
// Self-checking bench for the system error event gating block
`timescale 1ns/10ps
module tb
  import serr_mask_pkg::*;
;
  typedef struct packed {logic [7:0] ev; logic [7:0] mask; logic en; logic out_n; logic [7:0] stat;} row_type;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic error_report_enable = 1'b0;
  logic [7:0] ev = 8'h00;
  logic cfg_write, cfg_read, system_error_out_n;
  logic [7:0] cfg_offset;
  logic [3:0] be_n;
  logic [31:0] cfg_wdata, cfg_rdata, got;
  int mismatches = 0;
  int tests_run = 0;
  // Event bits, mask written, reporting enable, expected output and reason byte
  row_type rows [12] = '{
    '{8'h02, 8'h00, 1'b1, 1'b0, 8'h02}, '{8'h04, 8'h00, 1'b1, 1'b0, 8'h04}, '{8'h08, 8'h00, 1'b1, 1'b0, 8'h08},
    '{8'h10, 8'h00, 1'b1, 1'b0, 8'h10}, '{8'h20, 8'h00, 1'b1, 1'b0, 8'h20}, '{8'h40, 8'h00, 1'b1, 1'b0, 8'h40},
    '{8'h01, 8'h7E, 1'b1, 1'b0, 8'h01}, '{8'h80, 8'h7E, 1'b1, 1'b0, 8'h80}, '{8'h7E, 8'hFF, 1'b1, 1'b1, 8'h00},
    '{8'h02, 8'h00, 1'b0, 1'b1, 8'h00}, '{8'h40, 8'h3E, 1'b1, 1'b0, 8'h40}, '{8'h06, 8'h04, 1'b1, 1'b0, 8'h02}};

  bridge_serr_event_mask dut_u (.clk(clk), .srst(srst), .cfg_write(cfg_write), .cfg_read(cfg_read),
    .cfg_offset(cfg_offset), .primary_byte_enables_n(be_n), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .error_report_enable(error_report_enable), .addr_parity_event(ev[0]), .posted_parity_event(ev[1]),
    .posted_fail_event(ev[2]), .posted_target_abort_event(ev[3]), .posted_master_abort_event(ev[4]),
    .delayed_write_fail_event(ev[5]), .delayed_read_fail_event(ev[6]), .master_timeout_event(ev[7]),
    .system_error_out_n(system_error_out_n));
  cfg_host host_u (.clk(clk), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_offset(cfg_offset),
    .primary_byte_enables_n(be_n), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] act, input logic [31:0] exp, input string what);
    tests_run++;
    if (act !== exp) begin
      mismatches++;
      $display("unexpected %s at %0t: got %h want %h", what, $time, act, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // One-cycle event pulse; output is looked at in its single low cycle, then after it
  task automatic pulse(input logic [7:0] e, input logic en, input logic exp_n);
    @(negedge clk);
    error_report_enable = en;
    ev = e;
    @(negedge clk);
    ev = 8'h00;
    check(32'(system_error_out_n), 32'(exp_n), "error output");
    @(negedge clk);
    check(32'(system_error_out_n), 32'h0000_0001, "error release");
  endtask : pulse

  // Hang guard: a run this long means something stalled
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("unexpected timeout at %0t", $time);
    wrap_up();
  end

  initial begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    host_u.rd(disable_offset, got);
    check(got, 32'h0000_0000, "disable reset");
    foreach (rows[i]) begin
      host_u.wr(disable_offset, 4'b1110, {24'h00_0000, rows[i].mask});
      host_u.rd(disable_offset, got);
      check(got, {24'h00_0000, rows[i].mask & disable_writable}, "disable byte");
      pulse(rows[i].ev, rows[i].en, rows[i].out_n);
      host_u.rd(status_offset, got);
      check(got, {8'h00, rows[i].stat, 16'h0000}, "reason status");
      host_u.wr(status_offset, 4'b1011, 32'h00FF_0000);
      host_u.rd(status_offset, got);
      check(got, 32'h0000_0000, "status clear");
    end
    // Writes without lane 0, or to an unmapped offset, must leave the byte alone
    host_u.wr(disable_offset, 4'b1110, 32'h0000_0000);
    host_u.wr(disable_offset, 4'b1111, 32'hFFFF_FFFF);
    host_u.wr(8'h60, 4'b0000, 32'hFFFF_FFFF);
    host_u.rd(disable_offset, got);
    check(got, 32'h0000_0000, "lane gating");
    host_u.rd(8'h60, got);
    check(got, 32'h0000_0000, "unmapped read");
    // Clear without the status lane enabled is ignored
    pulse(8'h02, 1'b1, 1'b0);
    host_u.wr(status_offset, 4'b1111, 32'h00FF_0000);
    host_u.rd(status_offset, got);
    check(got, 32'h0002_0000, "status lane");
    // Event and clear in one cycle: the new reason survives, the old one goes
    fork
      host_u.wr(status_offset, 4'b1011, 32'h00FF_0000);
      pulse(8'h08, 1'b1, 1'b0);
    join
    host_u.rd(status_offset, got);
    check(got, 32'h0008_0000, "set beats clear");
    // Mid-run reset returns every register and the output to idle
    host_u.wr(disable_offset, 4'b1110, 32'h0000_003C);
    @(negedge clk);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    check(32'(system_error_out_n), 32'h0000_0001, "output after reset");
    host_u.rd(disable_offset, got);
    check(got, 32'h0000_0000, "disable after reset");
    host_u.rd(status_offset, got);
    check(got, 32'h0000_0000, "status after reset");
    wrap_up();
  end
endmodule : tb
